// *** design/bbxc_bit_unit.v ***
// Bit-level datapath: tests a bit and forms the bit exclusive-OR result.
// Assumes operands are stable while the main sequencer holds them.
module bbxc_bit_unit (
  input wire clk,
  input wire reset,
  input wire [7:0] src_byte,
  input wire [7:0] dst_byte,
  input wire [2:0] bit_index,
  input wire target_indexed,
  output reg test_bit_reg,
  output reg [7:0] xor_result_reg,
  output reg xor_bit_reg
);
  wire [7:0] mask;
  wire res_bit;
  assign mask = 8'h01 << bit_index;
  assign res_bit = target_indexed ?
                   (dst_byte[bit_index] ^ src_byte[0]) :
                   (dst_byte[0] ^ src_byte[bit_index]);
  always @(posedge clk) begin
    if (reset) begin
      test_bit_reg <= 1'b0;
      xor_result_reg <= 8'h00;
      xor_bit_reg <= 1'b0;
    end else begin
      test_bit_reg <= src_byte[bit_index];
      xor_bit_reg <= res_bit;
      if (target_indexed) begin
        xor_result_reg <= (dst_byte & ~mask) | ({8{res_bit}} & mask);
      end else begin
        xor_result_reg <= {dst_byte[7:1], res_bit};
      end
    end
  end
endmodule // bbxc_bit_unit

// *** design/bbxc_exec.v ***
// Execution sequencer for bit-test branches, bit exclusive-OR, call and return.
// Assumes register file, stack and program memory answer reads in the next cycle.
// Overview of operation
// - Opcode 37 with select 0 branches when the source bit is zero; 10 cycles.
// - Opcode 37 with select 1 branches when the source bit is one.
// - Branch not taken: continue at the instruction after the three bytes.
// - Displacement reaches from +127 down to -128 bytes.
// - Second byte: 4-bit register, 3-bit bit index, low select bit.
// - Branches and call leave every status flag unchanged.
// - Opcode 27 XORs a chosen bit with the other operand's bit zero.
// - Other destination bits and the source stay unchanged.
// - Zero set on zero result, sign cleared, others left alone.
// - Bit XOR is three bytes and six cycles; low bit picks target.
// - Call pushes low byte then high byte, decrementing SP, then loads PC.
// - Pushed address is the instruction after the call.
// - Call modes F6 3B 14cy, F4 2B 12cy, D4 2B 14cy.
// - Register-pair target: even register high, odd register low.
// - Vector target: first program byte high, next byte low.
// - Return pops two bytes from the stack top into the PC.
`include "bbxc_defines.vh"
module bbxc_exec (
  input wire CLK,
  input wire RESET,
  input wire START,
  input wire [7:0] OPCODE,
  input wire [7:0] BYTE2,
  input wire [7:0] BYTE3,
  input wire [15:0] PC_IN,
  input wire [15:0] SP_IN,
  input wire [7:0] FLAGS_IN,
  input wire [7:0] REG_RDATA,
  input wire [7:0] MEM_RDATA,
  output reg BUSY,
  output reg DONE,
  output reg ILLEGAL,
  output reg [15:0] PC_OUT,
  output reg PC_WE,
  output reg [15:0] SP_OUT,
  output reg SP_WE,
  output reg [7:0] FLAGS_OUT,
  output reg FLAGS_WE,
  output reg [7:0] REG_ADDR,
  output reg [7:0] REG_WDATA,
  output reg REG_WE,
  output reg [15:0] MEM_ADDR,
  output reg [7:0] MEM_WDATA,
  output reg MEM_WE,
  output reg MEM_PROG
);
  // ==========================================================
  // States
  localparam [8:0] S_IDLE = 9'h001;
  localparam [8:0] S_RD1 = 9'h002;
  localparam [8:0] S_RD2 = 9'h004;
  localparam [8:0] S_CALC = 9'h008;
  localparam [8:0] S_PUSHL = 9'h010;
  localparam [8:0] S_PUSHH = 9'h020;
  localparam [8:0] S_POPH = 9'h040;
  localparam [8:0] S_POPL = 9'h080;
  localparam [8:0] S_WAIT = 9'h100;
  reg [8:0] state_reg;
  reg [8:0] state_next;
  reg [7:0] opc_reg;
  reg [7:0] b2_reg;
  reg [7:0] b3_reg;
  reg [15:0] pc_reg;
  reg [15:0] sp_reg;
  reg [7:0] flags_reg;
  reg [7:0] op_a_reg;
  reg [7:0] op_b_reg;
  reg [15:0] target_reg;
  reg [4:0] cnt_reg;
  wire test_bit;
  wire [7:0] xor_byte;
  wire xor_bit;
  wire [15:0] next_pc;
  wire [15:0] disp_ext;
  wire is_branch;
  wire is_xor;
  wire is_call;
  wire is_ret;
  wire known;
  reg [4:0] cycles;
  // ==========================================================
  // Decode
  assign is_branch = (opc_reg == `BBXC_OPC_BIT_BRANCH);
  assign is_xor = (opc_reg == `BBXC_OPC_BIT_XOR);
  assign is_call = (opc_reg == `BBXC_OPC_CALL_DIRECT) ||
                   (opc_reg == `BBXC_OPC_CALL_PAIR) ||
                   (opc_reg == `BBXC_OPC_CALL_VECTOR);
  assign is_ret = (opc_reg == `BBXC_OPC_RETURN);
  assign known = (OPCODE == `BBXC_OPC_BIT_BRANCH) || (OPCODE == `BBXC_OPC_BIT_XOR) ||
                 (OPCODE == `BBXC_OPC_CALL_DIRECT) || (OPCODE == `BBXC_OPC_CALL_PAIR) ||
                 (OPCODE == `BBXC_OPC_CALL_VECTOR) || (OPCODE == `BBXC_OPC_RETURN);
  // Address of the following instruction
  assign next_pc = (opc_reg == `BBXC_OPC_CALL_DIRECT || is_branch || is_xor) ?
                   pc_reg + `BBXC_LEN_CALL_DIRECT :
                   pc_reg + `BBXC_LEN_CALL_SHORT;
  assign disp_ext = {{8{b3_reg[7]}}, b3_reg};
  always @* begin
    case (opc_reg)
      `BBXC_OPC_BIT_BRANCH: cycles = `BBXC_CYC_BIT_BRANCH;
      `BBXC_OPC_BIT_XOR: cycles = `BBXC_CYC_BIT_XOR;
      `BBXC_OPC_CALL_DIRECT: cycles = `BBXC_CYC_CALL_DIRECT;
      `BBXC_OPC_CALL_PAIR: cycles = `BBXC_CYC_CALL_PAIR;
      `BBXC_OPC_CALL_VECTOR: cycles = `BBXC_CYC_CALL_VECTOR;
      default: cycles = `BBXC_CYC_RETURN;
    endcase
  end
  // ==========================================================
  // Bit datapath
  bbxc_bit_unit u_bit (
    .clk(CLK),
    .reset(RESET),
    .src_byte(op_a_reg),
    .dst_byte(op_b_reg),
    .bit_index(b2_reg[3:1]),
    .target_indexed(b2_reg[0]),
    .test_bit_reg(test_bit),
    .xor_result_reg(xor_byte),
    .xor_bit_reg(xor_bit)
  );
  // ==========================================================
  // Next state
  always @* begin
    state_next = state_reg;
    case (state_reg)
      S_IDLE: if (START && known) state_next = S_RD1;
      S_RD1: state_next = S_RD2;
      S_RD2: begin
        if (is_call) state_next = S_PUSHL;
        else if (is_ret) state_next = S_POPH;
        else state_next = S_CALC;
      end
      S_CALC: state_next = S_WAIT;
      S_PUSHL: state_next = S_PUSHH;
      S_PUSHH: state_next = S_WAIT;
      S_POPH: state_next = S_POPL;
      S_POPL: state_next = S_WAIT;
      S_WAIT: if (cnt_reg >= cycles) state_next = S_IDLE;
      default: state_next = S_IDLE;
    endcase
  end
  // ==========================================================
  // Operand fetch addressing
  always @* begin
    REG_ADDR = 8'h00;
    MEM_ADDR = 16'h0000;
    MEM_PROG = 1'b0;
    case (state_reg)
      // Write address follows the registered write strobe
      S_IDLE: if (REG_WE) REG_ADDR = b2_reg[0] ? b3_reg : {4'h0, b2_reg[7:4]};
      S_RD1: begin
        if (is_branch) REG_ADDR = {4'h0, b2_reg[7:4]};
        else if (is_xor) REG_ADDR = b3_reg;
        else if (opc_reg == `BBXC_OPC_CALL_PAIR) REG_ADDR = {b2_reg[7:1], 1'b0};
        MEM_PROG = (opc_reg == `BBXC_OPC_CALL_VECTOR);
        MEM_ADDR = is_ret ? sp_reg : {8'h00, b2_reg};
      end
      S_RD2: begin
        if (is_xor) REG_ADDR = {4'h0, b2_reg[7:4]};
        else if (opc_reg == `BBXC_OPC_CALL_PAIR) REG_ADDR = {b2_reg[7:1], 1'b1};
        MEM_PROG = (opc_reg == `BBXC_OPC_CALL_VECTOR);
        MEM_ADDR = is_ret ? sp_reg + 16'h0001 : {8'h00, b2_reg} + 16'h0001;
      end
      // Push address follows the registered write strobe
      S_PUSHH: MEM_ADDR = sp_reg - 16'h0001;
      S_WAIT: if (MEM_WE) MEM_ADDR = sp_reg - 16'h0002;
      default: MEM_ADDR = 16'h0000;
    endcase
  end
  // ==========================================================
  // Sequencer registers
  always @(posedge CLK) begin
    if (RESET) begin
      state_reg <= S_IDLE;
      opc_reg <= 8'h00;
      b2_reg <= 8'h00;
      b3_reg <= 8'h00;
      pc_reg <= `BBXC_PC_RESET;
      sp_reg <= 16'h0000;
      flags_reg <= 8'h00;
      op_a_reg <= 8'h00;
      op_b_reg <= 8'h00;
      target_reg <= 16'h0000;
      cnt_reg <= 5'h00;
      BUSY <= 1'b0;
      DONE <= 1'b0;
      ILLEGAL <= 1'b0;
      PC_OUT <= `BBXC_PC_RESET;
      PC_WE <= 1'b0;
      SP_OUT <= 16'h0000;
      SP_WE <= 1'b0;
      FLAGS_OUT <= 8'h00;
      FLAGS_WE <= 1'b0;
      REG_WDATA <= 8'h00;
      REG_WE <= 1'b0;
      MEM_WDATA <= 8'h00;
      MEM_WE <= 1'b0;
    end else begin
      state_reg <= state_next;
      DONE <= 1'b0;
      ILLEGAL <= 1'b0;
      PC_WE <= 1'b0;
      SP_WE <= 1'b0;
      FLAGS_WE <= 1'b0;
      REG_WE <= 1'b0;
      MEM_WE <= 1'b0;
      cnt_reg <= (state_reg == S_IDLE) ? 5'h01 : cnt_reg + 5'h01;
      case (state_reg)
        S_IDLE: begin
          if (START) begin
            opc_reg <= OPCODE;
            b2_reg <= BYTE2;
            b3_reg <= BYTE3;
            pc_reg <= PC_IN;
            sp_reg <= SP_IN;
            flags_reg <= FLAGS_IN;
            BUSY <= known;
            ILLEGAL <= ~known;
          end
        end
        S_RD2: begin
          if (is_xor) begin
            if (b2_reg[0]) begin
              op_b_reg <= REG_RDATA;
            end else begin
              op_a_reg <= REG_RDATA;
            end
          end else if (is_branch) begin
            op_a_reg <= REG_RDATA;
          end else if (opc_reg == `BBXC_OPC_CALL_PAIR) begin
            target_reg[15:8] <= REG_RDATA;
          end else if (opc_reg == `BBXC_OPC_CALL_VECTOR) begin
            target_reg[15:8] <= MEM_RDATA;
          end else if (opc_reg == `BBXC_OPC_CALL_DIRECT) begin
            target_reg <= {b2_reg, b3_reg};
          end else if (is_ret) begin
            target_reg[15:8] <= MEM_RDATA;
          end
        end
        S_CALC: begin
          if (is_xor) begin
            if (b2_reg[0]) begin
              op_a_reg <= REG_RDATA;
            end else begin
              op_b_reg <= REG_RDATA;
            end
          end
        end
        S_PUSHL: begin
          if (opc_reg == `BBXC_OPC_CALL_PAIR) target_reg[7:0] <= REG_RDATA;
          if (opc_reg == `BBXC_OPC_CALL_VECTOR) target_reg[7:0] <= MEM_RDATA;
          MEM_WDATA <= next_pc[7:0];
          MEM_WE <= 1'b1;
        end
        S_PUSHH: begin
          MEM_WDATA <= next_pc[15:8];
          MEM_WE <= 1'b1;
          SP_OUT <= sp_reg - 16'h0002;
          SP_WE <= 1'b1;
        end
        S_POPH: target_reg[7:0] <= MEM_RDATA;
        S_POPL: begin
          SP_OUT <= sp_reg + 16'h0002;
          SP_WE <= 1'b1;
        end
        S_WAIT: begin
          if (cnt_reg >= cycles) begin
            BUSY <= 1'b0;
            DONE <= 1'b1;
            PC_WE <= 1'b1;
            if (is_branch) begin
              if (test_bit == b2_reg[0]) begin
                PC_OUT <= next_pc + disp_ext;
              end else begin
                PC_OUT <= next_pc;
              end
            end else if (is_xor) begin
              PC_OUT <= next_pc;
              REG_WDATA <= xor_byte;
              REG_WE <= 1'b1;
              FLAGS_OUT <= {flags_reg[7], ~xor_bit, 1'b0, flags_reg[4:0]};
              FLAGS_WE <= 1'b1;
            end else begin
              PC_OUT <= target_reg;
            end
          end
        end
        default: BUSY <= BUSY;
      endcase
    end
  end
endmodule // bbxc_exec

// *** pkg/bbxc_defines.vh ***
// Constants for the bit-branch, bit-xor and call execution block.
// Assumes one core clock at 40 MHz and an 8-bit register file.
`ifndef BBXC_DEFINES_VH
`define BBXC_DEFINES_VH
`define BBXC_OPC_BIT_BRANCH 8'h37
`define BBXC_OPC_BIT_XOR 8'h27
`define BBXC_OPC_CALL_DIRECT 8'hF6
`define BBXC_OPC_CALL_PAIR 8'hF4
`define BBXC_OPC_CALL_VECTOR 8'hD4
`define BBXC_OPC_RETURN 8'hAF
`define BBXC_CYC_BIT_BRANCH 5'h0A
`define BBXC_CYC_BIT_XOR 5'h06
`define BBXC_CYC_CALL_DIRECT 5'h0E
`define BBXC_CYC_CALL_PAIR 5'h0C
`define BBXC_CYC_CALL_VECTOR 5'h0E
`define BBXC_CYC_RETURN 5'h08
`define BBXC_LEN_BIT_BRANCH 16'h0003
`define BBXC_LEN_BIT_XOR 16'h0003
`define BBXC_LEN_CALL_DIRECT 16'h0003
`define BBXC_LEN_CALL_SHORT 16'h0002
`define BBXC_FLAG_ZERO 3'h6
`define BBXC_FLAG_SIGN 3'h5
`define BBXC_FLAG_OVF 3'h4
`define BBXC_PC_RESET 16'h0000
`endif

// *** verif/bbxc_exec_chk.sv ***
// Timing and result checks on the execution block's ports.
// Assumes one clock and synchronous active-high reset.
module bbxc_exec_chk (
  input wire CLK,
  input wire RESET,
  input wire START,
  input wire [7:0] OPCODE,
  input wire [7:0] BYTE2,
  input wire [7:0] BYTE3,
  input wire [15:0] PC_IN,
  input wire [15:0] SP_IN,
  input wire BUSY,
  input wire DONE,
  input wire [15:0] PC_OUT,
  input wire PC_WE,
  input wire [15:0] SP_OUT,
  input wire SP_WE,
  input wire [7:0] FLAGS_OUT,
  input wire FLAGS_WE,
  input wire [15:0] MEM_ADDR,
  input wire [7:0] MEM_WDATA,
  input wire MEM_WE
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] op_q, b2_q, b3_q;
  logic [15:0] pc_q, sp_q;
  wire [15:0] ret = pc_q + ((op_q == 8'hF6) ? 16'h0003 : 16'h0002);
  wire call_q = op_q == 8'hF6 || op_q == 8'hF4 || op_q == 8'hD4;
  // ==========
  // Operands of the instruction in flight
  always @(posedge CLK) begin
    if (RESET) begin
      op_q <= 8'h00;
    end else if (START && !BUSY) begin
      op_q <= OPCODE;
      b2_q <= BYTE2;
      b3_q <= BYTE3;
      pc_q <= PC_IN;
      sp_q <= SP_IN;
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  cyc_branch_a: assert property (START && !BUSY && OPCODE == 8'h37 |-> ##[10:11] DONE)
    else $error("bit branch length wrong");
  cyc_xor_a: assert property (START && !BUSY && OPCODE == 8'h27 |-> ##[6:7] DONE)
    else $error("bit xor length wrong");
  cyc_pair_a: assert property (START && !BUSY && OPCODE == 8'hF4 |-> ##[12:13] DONE)
    else $error("pair call length wrong");
  flags_keep_a: assert property (START && !BUSY && OPCODE != 8'h27 && OPCODE != 8'hAF
    |=> !FLAGS_WE [*8]) else $error("flags written");
  sign_clear_a: assert property (FLAGS_WE |-> !FLAGS_OUT[5] && op_q == 8'h27)
    else $error("sign flag or source of flag write wrong");
  br_target_a: assert property (PC_WE && op_q == 8'h37 |-> PC_OUT == pc_q + 16'h0003
    || PC_OUT == pc_q + 16'h0003 + {{8{b3_q[7]}}, b3_q}) else $error("branch target wrong");
  push_low_a: assert property (MEM_WE && MEM_ADDR == sp_q - 16'h0001
    |-> MEM_WDATA == ret[7:0]) else $error("pushed low byte wrong");
  push_high_a: assert property (MEM_WE && MEM_ADDR == sp_q - 16'h0002
    |-> MEM_WDATA == ret[15:8]) else $error("pushed high byte wrong");
  sp_call_a: assert property (SP_WE && call_q |-> SP_OUT == sp_q - 16'h0002)
    else $error("stack pointer after call wrong");
  direct_a: assert property (PC_WE && op_q == 8'hF6 |-> PC_OUT == {b2_q, b3_q})
    else $error("direct call target wrong");
endmodule // bbxc_exec_chk
bind bbxc_exec bbxc_exec_chk i_chk (.CLK(CLK), .RESET(RESET), .START(START), .OPCODE(OPCODE),
  .BYTE2(BYTE2), .BYTE3(BYTE3), .PC_IN(PC_IN), .SP_IN(SP_IN), .BUSY(BUSY), .DONE(DONE),
  .PC_OUT(PC_OUT), .PC_WE(PC_WE), .SP_OUT(SP_OUT), .SP_WE(SP_WE), .FLAGS_OUT(FLAGS_OUT),
  .FLAGS_WE(FLAGS_WE), .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA), .MEM_WE(MEM_WE));

// *** verif/bbxc_mem_model.sv ***
// Register file, stack and program memory facing the execution block.
// Assumes reads answer one cycle after the address; only the stack is written.
module bbxc_mem_model (
  input wire clk,
  input wire [7:0] reg_addr,
  output logic [7:0] reg_rdata,
  input wire [15:0] mem_addr,
  input wire mem_prog,
  input wire mem_we,
  input wire [7:0] mem_wdata,
  output logic [7:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] regs [0:255];
  logic [7:0] prog [0:255];
  logic [7:0] stack [0:255];
  // ==========
  // Registered read port, stack writes
  always @(posedge clk) begin
    reg_rdata <= regs[reg_addr];
    mem_rdata <= mem_prog ? prog[mem_addr[7:0]] : stack[mem_addr[7:0]];
    if (mem_we) begin
      stack[mem_addr[7:0]] <= mem_wdata;
    end
  end
endmodule // bbxc_mem_model

// *** verif/tb_top.sv ***
// Self-checking bench: one instruction per run, results judged at the ports and in the stack model.
// Assumes the memory model answers reads one cycle after the address.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK = 0;
  logic RESET = 1;
  logic START = 0;
  logic [7:0] OPCODE = 0, BYTE2 = 0, BYTE3 = 0, FLAGS_IN = 0;
  logic [15:0] PC_IN = 0, SP_IN = 0;
  wire BUSY, DONE, ILLEGAL, PC_WE, SP_WE, FLAGS_WE, REG_WE, MEM_WE, MEM_PROG;
  wire [15:0] PC_OUT, SP_OUT, MEM_ADDR;
  wire [7:0] FLAGS_OUT, REG_ADDR, REG_WDATA, MEM_WDATA, REG_RDATA, MEM_RDATA;
  int errors = 0, n_tests = 0, n_done, n_ill, n_fl;
  logic [15:0] pc_seen, sp_seen;
  logic [7:0] fl_seen, wd_seen, wa_seen;
  always #12.5 CLK = ~CLK;
  bbxc_exec i_dut (.CLK(CLK), .RESET(RESET), .START(START), .OPCODE(OPCODE), .BYTE2(BYTE2),
    .BYTE3(BYTE3), .PC_IN(PC_IN), .SP_IN(SP_IN), .FLAGS_IN(FLAGS_IN), .REG_RDATA(REG_RDATA),
    .MEM_RDATA(MEM_RDATA), .BUSY(BUSY), .DONE(DONE), .ILLEGAL(ILLEGAL), .PC_OUT(PC_OUT),
    .PC_WE(PC_WE), .SP_OUT(SP_OUT), .SP_WE(SP_WE), .FLAGS_OUT(FLAGS_OUT), .FLAGS_WE(FLAGS_WE),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WE(REG_WE), .MEM_ADDR(MEM_ADDR),
    .MEM_WDATA(MEM_WDATA), .MEM_WE(MEM_WE), .MEM_PROG(MEM_PROG));
  bbxc_mem_model i_mem (.clk(CLK), .reg_addr(REG_ADDR), .reg_rdata(REG_RDATA),
    .mem_addr(MEM_ADDR), .mem_prog(MEM_PROG), .mem_we(MEM_WE), .mem_wdata(MEM_WDATA),
    .mem_rdata(MEM_RDATA));
  // ==========
  // Output monitor
  always @(posedge CLK) begin
    if (DONE) n_done++;
    if (ILLEGAL) n_ill++;
    if (PC_WE) pc_seen = PC_OUT;
    if (SP_WE) sp_seen = SP_OUT;
    if (FLAGS_WE) begin
      fl_seen = FLAGS_OUT;
      n_fl++;
    end
    if (REG_WE) begin
      wd_seen = REG_WDATA;
      wa_seen = REG_ADDR;
    end
  end
  task chk(input [15:0] got, input [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task end_sim;
    $display("errors %0d of %0d compares", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task fill(input [7:0] hi, input [7:0] lo);
    for (int a = 0; a < 256; a++) i_mem.regs[a] = a[0] ? lo : hi;
  endtask
  // For a known opcode the second START cycle arrives while busy and must be ignored
  task run(input [7:0] o, b2, b3, input [15:0] pc, sp, input [7:0] fl);
    n_done = 0; n_ill = 0; n_fl = 0;
    pc_seen = 'x; sp_seen = 'x; fl_seen = 'x; wd_seen = 'x; wa_seen = 'x;
    @(posedge CLK);
    #2 {OPCODE, BYTE2, BYTE3, PC_IN, SP_IN, FLAGS_IN, START} = {o, b2, b3, pc, sp, fl, 1'b1};
    repeat (2) @(posedge CLK);
    #2 START = 0;
    for (int i = 0; i < 40 && n_done == 0 && n_ill == 0; i++) @(posedge CLK);
    if (n_done == 0 && n_ill == 0) begin
      errors++;
      end_sim;
    end
    repeat (2) @(posedge CLK);
    #2;
  endtask
  task t_branch(input sel, input [2:0] b, input [7:0] d);
    fill(8'hF8, 8'h07);
    run(8'h37, {4'h1, b, sel}, d, 16'h1A47, 16'h0100, 8'hA5);
    if (((8'h07 >> b) & 8'h01) == {7'h00, sel}) chk(pc_seen, 16'h1A4A + {{8{d[7]}}, d});
    else chk(pc_seen, 16'h1A4A);
    chk(n_fl, 0);
    chk(n_done, 1);
  endtask
  // Working register 1 holds wk, register 2 holds rg
  task t_xor(input sel, input [2:0] b, input [7:0] wk, rg, fl);
    logic r;
    logic [7:0] w;
    r = wk[0] ^ rg[b];
    w = sel ? rg : wk;
    if (sel) w[b] = r;
    else w[0] = r;
    fill(rg, wk);
    run(8'h27, {4'h1, b, sel}, 8'h02, 16'h0200, 16'h0100, fl);
    chk(wd_seen, w);
    chk(wa_seen, sel ? 8'h02 : 8'h01);
    chk(fl_seen & 8'hEF, {fl[7], ~r, 2'b00, fl[3:0]});
    chk(n_done, 1);
  endtask
  task t_call(input [7:0] o, b2, b3);
    logic [15:0] ret;
    ret = 16'h1A47 + (o == 8'hF6 ? 16'h0003 : 16'h0002);
    fill(8'h35, 8'h21);
    run(o, b2, b3, 16'h1A47, 16'h0002, 8'h5A);
    chk(pc_seen, 16'h3521);
    chk(sp_seen, 16'h0000);
    chk(i_mem.stack[1], ret[7:0]);
    chk(i_mem.stack[0], ret[15:8]);
    chk(n_fl, 0);
  endtask
  initial begin
    i_mem.prog[8'h40] = 8'h35;
    i_mem.prog[8'h41] = 8'h21;
    repeat (6) @(posedge CLK);
    #2 RESET = 0;
    t_branch(0, 3, 8'h7F);
    t_branch(0, 1, 8'h80);
    t_branch(1, 1, 8'h80);
    t_branch(1, 3, 8'h7F);
    t_xor(0, 1, 8'h07, 8'h03, 8'hFF);
    t_xor(1, 2, 8'h07, 8'h03, 8'h00);
    t_xor(1, 7, 8'h01, 8'h81, 8'h0F);
    t_call(8'hF6, 8'h35, 8'h21);
    t_call(8'hF4, 8'h00, 8'h00);
    t_call(8'hD4, 8'h40, 8'h00);
    run(8'hAF, 8'h00, 8'h00, 16'h3521, 16'h0000, 8'h00);
    chk(pc_seen, 16'h1A49);
    chk(sp_seen, 16'h0002);
    run(8'h00, 8'h00, 8'h00, 16'h0000, 16'h0100, 8'h00);
    chk(n_done, 0);
    chk(n_ill, 2);
    end_sim;
  end
endmodule // tb_top
